// file: core/ppfs_defines.svh
// Constants for the port pin function select block.
// Contract
// R1 - Four-bit port, each bit input or output by its direction register bit.
// R2 - Four-bit port pins get on-chip pull-up when its pull-up register enables it; the code gives it only while the bit is not driven and not in reset.
// R3 - Single I/O pin has own direction and pull-up enable registers.
// R4 - Reset-shared pin used as port is input only, never driven.
// R5 - Two-bit port has per-bit direction and separate pull-up enable register.
// R6 - Each multi-function pin selects port or control mode individually.
// R7 - External interrupt inputs detect rising, falling or both edges, selectable.
// R8 - Control mode: quad bit 0 drives the timer waveform.
// R9 - Control mode: quad bit 1 is interrupt A, single pin is interrupt B.
// R10 - Option byte selects quad bit 3 as external main clock input.
// R11 - Reset-shared pin is active-low reset at power-on; option may make it input.
// R12 - During reset, quad bits 2 and 3 are pulled down.
// R13 - During reset, the reset-shared pin is pulled up.
// R14 - Board supplies a pull-up when reset-shared pin is a general input.
// R15 - Unused reset-shared input: option pull-up enable set to 1, pin open.
// R16 - After any reset all pins are inputs with drivers disabled.
`ifndef PPFS_DEFINES_SVH
`define PPFS_DEFINES_SVH
`define PPFS_QUAD_W     4
`define PPFS_DUAL_W     2
`define PPFS_QUAD_RST   4'h0
`define PPFS_DUAL_RST   2'h0
`define PPFS_BIT_RST    1'h0
`define PPFS_WAVE_BIT   0
`define PPFS_IRQA_BIT   1
`define PPFS_PD_LO_BIT  2
`define PPFS_CLK_BIT    3
`define PPFS_EDGE_RISE  2'h1
`define PPFS_EDGE_FALL  2'h2
`define PPFS_EDGE_BOTH  2'h3
`endif

// file: core/ppfs_pkg.sv
// Types for the port pin function select block.
package ppfs_pkg;
   typedef enum logic [1:0] {
      PPFS_EDGE_NONE_E,
      PPFS_EDGE_RISE_E,
      PPFS_EDGE_FALL_E,
      PPFS_EDGE_BOTH_E
   } ppfs_edge_t;
endpackage

// file: core/ppfs_port_pin_function_select.sv
// Pin-level port and alternate-function logic for four small ports.
`timescale 1ns/100ps
`default_nettype none
`include "ppfs_defines.svh"
module ppfs_port_pin_function_select #(
   parameter int QUAD_W = `PPFS_QUAD_W,
   parameter int DUAL_W = `PPFS_DUAL_W
) (
   // Clock and synchronous reset.
   input  wire logic              sys_clk_in,
   input  wire logic              rst_in,
   // Four-bit port controls and pins.
   input  wire logic [QUAD_W-1:0] quad_dir_reg_in,
   input  wire logic [QUAD_W-1:0] quad_pullup_reg_in,
   input  wire logic [QUAD_W-1:0] quad_ctrl_mode_in,
   input  wire logic [QUAD_W-1:0] quad_out_data_in,
   input  wire logic [QUAD_W-1:0] quad_pin_in,
   output logic      [QUAD_W-1:0] quad_pin_out,
   output logic      [QUAD_W-1:0] quad_pin_oe_out,
   output logic      [QUAD_W-1:0] quad_pullup_out,
   output logic      [QUAD_W-1:0] quad_pulldown_out,
   output logic      [QUAD_W-1:0] quad_data_out,
   // Single I/O pin controls and pin.
   input  wire logic              single_dir_reg_in,
   input  wire logic              single_pullup_reg_in,
   input  wire logic              single_ctrl_mode_in,
   input  wire logic              single_out_data_in,
   input  wire logic              single_io_pin_in,
   output logic                   single_io_pin_out,
   output logic                   single_io_pin_oe_out,
   output logic                   single_pullup_out,
   output logic                   single_data_out,
   // Reset-shared input pin.
   input  wire logic              reset_shared_input_in,
   input  wire logic              reset_pin_as_port_in,
   input  wire logic              reset_pin_pullup_en_in,
   output logic                   reset_shared_pullup_out,
   output logic                   reset_shared_data_out,
   output logic                   sys_reset_n_out,
   // Two-bit port controls and pins.
   input  wire logic [DUAL_W-1:0] dual_dir_reg_in,
   input  wire logic [DUAL_W-1:0] dual_pullup_reg_in,
   input  wire logic [DUAL_W-1:0] dual_out_data_in,
   input  wire logic [DUAL_W-1:0] dual_pin_in,
   output logic      [DUAL_W-1:0] dual_pin_out,
   output logic      [DUAL_W-1:0] dual_pin_oe_out,
   output logic      [DUAL_W-1:0] dual_pullup_out,
   output logic      [DUAL_W-1:0] dual_data_out,
   // Alternate functions.
   input  wire logic              timer_wave_out_in,
   input  wire logic              ext_clk_sel_in,
   input  wire logic [1:0]        ext_irq_a_edge_in,
   input  wire logic [1:0]        ext_irq_b_edge_in,
   output logic                   ext_irq_a_out,
   output logic                   ext_irq_b_out,
   output logic                   ext_main_clk_in_out
);

   // Synchroniser stages and edge history, one group of state.
   logic [QUAD_W-1:0] quad_s1_q, quad_s1_d, quad_s2_q, quad_s2_d;
   logic [DUAL_W-1:0] dual_s1_q, dual_s1_d, dual_s2_q, dual_s2_d;
   logic [2:0]        misc_s1_q, misc_s1_d, misc_s2_q, misc_s2_d;
   logic [1:0]        irq_prev_q, irq_prev_d;
   logic [1:0]        irq_q, irq_d;
   logic              por_done_q, por_done_d;
   logic              irq_a_lvl, irq_b_lvl;
   ppfs_pkg::ppfs_edge_t edge_a, edge_b;

   // Edge match helper for one interrupt source.
   function automatic logic edge_hit(input ppfs_pkg::ppfs_edge_t sel,
                                     input logic prev, input logic cur);
      logic hit;
      hit = 1'b0;
      case (sel)
         ppfs_pkg::PPFS_EDGE_RISE_E: hit = ~prev & cur;
         ppfs_pkg::PPFS_EDGE_FALL_E: hit = prev & ~cur;
         ppfs_pkg::PPFS_EDGE_BOTH_E: hit = prev ^ cur;
         default:                    hit = 1'b0;
      endcase
      return hit;
   endfunction

   assign edge_a = ppfs_pkg::ppfs_edge_t'(ext_irq_a_edge_in);
   assign edge_b = ppfs_pkg::ppfs_edge_t'(ext_irq_b_edge_in);

   // Interrupt levels are masked to zero while the pin is in port mode.
   assign irq_a_lvl = quad_ctrl_mode_in[`PPFS_IRQA_BIT] & quad_s2_q[`PPFS_IRQA_BIT]; // R9
   assign irq_b_lvl = single_ctrl_mode_in & misc_s2_q[0]; // R9

   // Next state: two-flop synchronisers, edge detection, power-on tracking.
   always_comb begin
      quad_s1_d  = quad_pin_in;
      quad_s2_d  = quad_s1_q;
      dual_s1_d  = dual_pin_in;
      dual_s2_d  = dual_s1_q;
      misc_s1_d  = {ext_clk_sel_in, reset_shared_input_in, single_io_pin_in};
      misc_s2_d  = misc_s1_q;
      irq_prev_d = {irq_b_lvl, irq_a_lvl};
      irq_d[0]   = edge_hit(edge_a, irq_prev_q[0], irq_a_lvl); // R7
      irq_d[1]   = edge_hit(edge_b, irq_prev_q[1], irq_b_lvl); // R7
      por_done_d = 1'b1;
   end

   // Registers the state above; reset clears everything.
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         quad_s1_q  <= `PPFS_QUAD_RST;
         quad_s2_q  <= `PPFS_QUAD_RST;
         dual_s1_q  <= `PPFS_DUAL_RST;
         dual_s2_q  <= `PPFS_DUAL_RST;
         misc_s1_q  <= 3'h0;
         misc_s2_q  <= 3'h0;
         irq_prev_q <= 2'h0;
         irq_q      <= 2'h0;
         por_done_q <= `PPFS_BIT_RST;
      end else begin
         quad_s1_q  <= quad_s1_d;
         quad_s2_q  <= quad_s2_d;
         dual_s1_q  <= dual_s1_d;
         dual_s2_q  <= dual_s2_d;
         misc_s1_q  <= misc_s1_d;
         misc_s2_q  <= misc_s2_d;
         irq_prev_q <= irq_prev_d;
         irq_q      <= irq_d;
         por_done_q <= por_done_d;
      end
   end

   // Four-bit port drive, one generate slice per bit.
   for (genvar i = 0; i < QUAD_W; i++) begin : g_quad
      logic clk_pin;
      assign clk_pin = (i == `PPFS_CLK_BIT) && ext_clk_sel_in;
      always_comb begin
         quad_pin_oe_out[i] = 1'b0;
         quad_pin_out[i]    = quad_out_data_in[i];
         if (rst_in || clk_pin) begin
            quad_pin_oe_out[i] = 1'b0; // R16 R10
         end else if (quad_ctrl_mode_in[i] && i == `PPFS_WAVE_BIT) begin
            quad_pin_oe_out[i] = 1'b1; // R6 R8
            quad_pin_out[i]    = timer_wave_out_in; // R8
         end else if (!quad_ctrl_mode_in[i]) begin
            quad_pin_oe_out[i] = ~quad_dir_reg_in[i]; // R1
         end
         // Pull-up only while the bit is not driven, in port or control mode.
         quad_pullup_out[i] = ~rst_in & quad_pullup_reg_in[i] & ~quad_pin_oe_out[i]; // R2
         quad_pulldown_out[i] = rst_in && (i >= `PPFS_PD_LO_BIT); // R12
      end
   end

   // Two-bit port drive.
   for (genvar j = 0; j < DUAL_W; j++) begin : g_dual
      always_comb begin
         dual_pin_oe_out[j] = ~rst_in & ~dual_dir_reg_in[j]; // R5 R16
         dual_pin_out[j]    = dual_out_data_in[j];
         dual_pullup_out[j] = ~rst_in & dual_pullup_reg_in[j] & dual_dir_reg_in[j]; // R5
      end
   end

   // Single I/O pin drive; in control mode it is an interrupt input.
   assign single_io_pin_oe_out = ~rst_in & ~single_ctrl_mode_in & ~single_dir_reg_in; // R3 R16
   assign single_io_pin_out    = single_out_data_in;
   assign single_pullup_out    = ~rst_in & single_pullup_reg_in & ~single_io_pin_oe_out; // R3

   // Reset-shared pin: never driven, pulled up in reset or when option enables it.
   assign reset_shared_pullup_out = rst_in | reset_pin_pullup_en_in; // R13 R15
   assign reset_shared_data_out   = reset_pin_as_port_in & misc_s2_q[1]; // R4
   // Acts as reset until power-on completes, then only if not reassigned.
   assign sys_reset_n_out = (por_done_q && reset_pin_as_port_in) ? 1'b1 : misc_s2_q[1]; // R11

   // Synchronised read data and alternate-function outputs.
   assign quad_data_out       = quad_s2_q;
   assign dual_data_out       = dual_s2_q;
   assign single_data_out     = misc_s2_q[0];
   assign ext_irq_a_out       = irq_q[0];
   assign ext_irq_b_out       = irq_q[1];
   assign ext_main_clk_in_out = quad_pin_in[`PPFS_CLK_BIT] & ext_clk_sel_in; // R10

   // Checks.
   a_reset_inputs: assert property (@(posedge sys_clk_in) rst_in |->
      (quad_pin_oe_out == '0 && dual_pin_oe_out == '0 && !single_io_pin_oe_out)) // R16
      else $error("pin driven during reset");
   a_quad_dir: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (!quad_ctrl_mode_in[1] && !quad_dir_reg_in[1]) |-> quad_pin_oe_out[1]) // R1
      else $error("quad bit1 not driven as output");
   a_quad_pullup: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (quad_pullup_reg_in[2] && quad_dir_reg_in[2]) |-> quad_pullup_out[2]) // R2
      else $error("quad pull-up missing");
   a_single_dir: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      single_ctrl_mode_in |-> !single_io_pin_oe_out) // R3
      else $error("single pin driven in control mode");
   a_dual_dir: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      1'b1 |-> dual_pin_oe_out == ~dual_dir_reg_in) // R5
      else $error("dual direction inverted");
   a_wave_out: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      quad_ctrl_mode_in[0] |-> (quad_pin_oe_out[0] && quad_pin_out[0] == timer_wave_out_in)) // R8
      else $error("timer wave not on pin");
   a_pulldown: assert property (@(posedge sys_clk_in)
      rst_in |-> quad_pulldown_out == 4'hc) // R12
      else $error("pull-down wrong in reset");
   a_rst_pullup: assert property (@(posedge sys_clk_in)
      rst_in |-> reset_shared_pullup_out) // R13
      else $error("reset pin not pulled up");
   a_irq_rise: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (edge_a == ppfs_pkg::PPFS_EDGE_RISE_E && !irq_a_lvl ##1 irq_a_lvl
       && edge_a == ppfs_pkg::PPFS_EDGE_RISE_E) |=> ext_irq_a_out) // R7
      else $error("rising edge missed on irq a");

endmodule // ppfs_port_pin_function_select
`default_nettype wire

// file: verification/ppfs_board_model.sv
// Board-side model of a group of pins: board drivers, pulls and open lines.
`timescale 1ns/100ps
`default_nettype none
module ppfs_board_model #(
   parameter int W        = 1,
   parameter bit BOARD_PU = 1'b0
) (
   // Device side of the pins.
   input  wire logic         sys_clk_in,
   input  wire logic [W-1:0] oe_in,
   input  wire logic [W-1:0] drv_in,
   input  wire logic [W-1:0] pu_in,
   input  wire logic [W-1:0] pd_in,
   // Board drivers commanded by the bench, and resolved levels.
   input  wire logic [W-1:0] ext_en_in,
   input  wire logic [W-1:0] ext_val_in,
   output logic      [W-1:0] level_out
);
   logic flip_q = 1'b0;
   // An open line with no pull is never trusted, so it toggles every cycle.
   always_ff @(posedge sys_clk_in) flip_q <= ~flip_q;
   // Board drive wins, then the device driver, then the pulls.
   always_comb begin
      for (int i = 0; i < W; i++) begin
         if (ext_en_in[i]) level_out[i] = ext_val_in[i];
         else if (oe_in[i]) level_out[i] = drv_in[i];
         else if (pu_in[i] || BOARD_PU) level_out[i] = 1'b1;
         else if (pd_in[i]) level_out[i] = 1'b0;
         else level_out[i] = flip_q;
      end
   end
endmodule // ppfs_board_model
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the port pin function select block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
   $display("[ERR] %0t got %h want %h", $time, a, e); end end
module tb_top;
   logic sys_clk_in = 1'b0, rst_in = 1'b1, timer_wave_out_in = 1'b0, ext_clk_sel_in = 1'b0;
   logic [3:0] quad_dir_reg_in = 4'h0, quad_pullup_reg_in = 4'h0, quad_ctrl_mode_in = 4'h0;
   logic [3:0] quad_out_data_in = 4'h0, q_en = 4'h0, q_val = 4'h0, quad_pin_in, quad_pin_out;
   logic [3:0] quad_pin_oe_out, quad_pullup_out, quad_pulldown_out, quad_data_out;
   logic single_dir_reg_in = 1'b0, single_pullup_reg_in = 1'b0, single_ctrl_mode_in = 1'b0;
   logic single_out_data_in = 1'b0, s_en = 1'b0, s_val = 1'b0, single_io_pin_in;
   logic single_io_pin_out, single_io_pin_oe_out, single_pullup_out, single_data_out;
   logic reset_pin_as_port_in = 1'b0, reset_pin_pullup_en_in = 1'b0, r_en = 1'b0, r_val = 1'b0;
   logic reset_shared_input_in, reset_shared_pullup_out, reset_shared_data_out, sys_reset_n_out;
   logic [1:0] dual_dir_reg_in = 2'h0, dual_pullup_reg_in = 2'h0, dual_out_data_in = 2'h0;
   logic [1:0] d_en = 2'h0, d_val = 2'h0, dual_pin_in, dual_pin_out, dual_pin_oe_out;
   logic [1:0] dual_pullup_out, dual_data_out, ext_irq_a_edge_in = 2'h0, ext_irq_b_edge_in = 2'h0;
   logic ext_irq_a_out, ext_irq_b_out, ext_main_clk_in_out;
   int bad_count = 0, samples_checked = 0, cycles = 0, na = 0, nb = 0, a0, b0;
   int exp_n [5] = '{0, 1, 1, 2, 0};
   ppfs_port_pin_function_select u_dut (.*);
   ppfs_board_model #(.W(4)) u_quad (.sys_clk_in(sys_clk_in), .oe_in(quad_pin_oe_out),
      .drv_in(quad_pin_out), .pu_in(quad_pullup_out), .pd_in(quad_pulldown_out),
      .ext_en_in(q_en), .ext_val_in(q_val), .level_out(quad_pin_in));
   ppfs_board_model #(.W(1)) u_single (.sys_clk_in(sys_clk_in), .oe_in(single_io_pin_oe_out),
      .drv_in(single_io_pin_out), .pu_in(single_pullup_out), .pd_in(1'b0),
      .ext_en_in(s_en), .ext_val_in(s_val), .level_out(single_io_pin_in));
   ppfs_board_model #(.W(2)) u_dual (.sys_clk_in(sys_clk_in), .oe_in(dual_pin_oe_out),
      .drv_in(dual_pin_out), .pu_in(dual_pullup_out), .pd_in(2'h0),
      .ext_en_in(d_en), .ext_val_in(d_val), .level_out(dual_pin_in));
   // The reset-shared pin has no device driver, so its drive value simply mirrors the board.
   ppfs_board_model #(.W(1), .BOARD_PU(1'b1)) u_rst_pin (.sys_clk_in(sys_clk_in), .oe_in(1'b0),
      .drv_in(r_val), .pu_in(reset_shared_pullup_out), .pd_in(1'b0),
      .ext_en_in(r_en), .ext_val_in(r_val), .level_out(reset_shared_input_in));
   // Clock, interrupt pulse counters and hang guard.
   always #25 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in) begin
      cycles++;
      na += (ext_irq_a_out === 1'b1);
      nb += (ext_irq_b_out === 1'b1);
      if (cycles == 3000) begin
         bad_count++;
         give_verdict();
      end
   end
   task step(input int n); repeat (n) @(posedge sys_clk_in); endtask
   task look; @(negedge sys_clk_in); endtask
   task give_verdict;
      $display("checks %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Reset with every pin asked to drive, so the reset state must override.
   task rst_chk;
      step(1); rst_in <= 1'b1; quad_dir_reg_in <= 4'h0; single_dir_reg_in <= 1'b0;
      dual_dir_reg_in <= 2'h0; step(3); look;
      `CHK({quad_pin_oe_out, single_io_pin_oe_out, dual_pin_oe_out}, 7'h0)
      `CHK(quad_pulldown_out, 4'hc)
      `CHK(reset_shared_pullup_out, 1'b1)
      step(1); rst_in <= 1'b0;
   endtask
   // Main sequence of scenarios.
   initial begin
      rst_chk();
      step(1); quad_dir_reg_in <= 4'hf; single_dir_reg_in <= 1'b1; dual_dir_reg_in <= 2'h3; look;
      `CHK({quad_pin_oe_out, single_io_pin_oe_out, dual_pin_oe_out}, 7'h0)
      `CHK(quad_pulldown_out, 4'h0)
      step(1); quad_dir_reg_in <= 4'h3; quad_pullup_reg_in <= 4'hf; quad_out_data_in <= 4'ha;
      dual_dir_reg_in <= 2'h1; dual_pullup_reg_in <= 2'h3; single_out_data_in <= 1'b1;
      single_dir_reg_in <= 1'b0; step(3); look;
      `CHK(sys_reset_n_out, 1'b1)
      `CHK({quad_pin_oe_out, quad_pin_out & 4'hc}, 8'hc8)
      `CHK({quad_pullup_out, quad_data_out}, 8'h3b)
      `CHK({dual_pin_oe_out, dual_pullup_out, dual_data_out}, 6'h25)
      `CHK({single_io_pin_oe_out, single_io_pin_out, single_data_out}, 3'h7)
      step(1); single_dir_reg_in <= 1'b1; single_pullup_reg_in <= 1'b1; look;
      `CHK({single_io_pin_oe_out, single_pullup_out}, 2'h1)
      step(1); quad_dir_reg_in <= 4'h2; quad_ctrl_mode_in <= 4'h1;
      for (int v = 0; v < 2; v++) begin
         step(1); timer_wave_out_in <= v[0]; quad_out_data_in <= {3'h0, ~v[0]}; look;
         `CHK({quad_pin_oe_out[0], quad_pin_out[0]}, {1'b1, v[0]})
      end
      step(1); ext_clk_sel_in <= 1'b1; quad_dir_reg_in <= 4'h0; q_en <= 4'h8;
      for (int v = 0; v < 2; v++) begin
         step(1); q_val <= {v[0], 3'h0}; look;
         `CHK({quad_pin_oe_out[3], ext_main_clk_in_out}, {1'b0, v[0]})
      end
      step(1); ext_clk_sel_in <= 1'b0; quad_dir_reg_in <= 4'hf; q_en <= 4'h2; q_val <= 4'h0;
      s_en <= 1'b1;
      for (int m = 0; m < 5; m++) begin
         step(1); ext_irq_a_edge_in <= (m == 4) ? 2'h3 : m[1:0];
         ext_irq_b_edge_in <= (m == 4) ? 2'h3 : m[1:0];
         quad_ctrl_mode_in <= (m == 4) ? 4'h0 : 4'h2; single_ctrl_mode_in <= (m != 4);
         step(4); a0 = na; b0 = nb; q_val <= 4'h2; s_val <= 1'b1;
         step(5); q_val <= 4'h0; s_val <= 1'b0; step(6);
         `CHK({na - a0, nb - b0}, {exp_n[m], exp_n[m]})
      end
      step(1); r_en <= 1'b1; r_val <= 1'b0; step(4); look;
      `CHK(sys_reset_n_out, 1'b0)
      step(1); reset_pin_as_port_in <= 1'b1; step(4); look;
      `CHK({sys_reset_n_out, reset_shared_data_out}, 2'h2)
      step(1); r_val <= 1'b1; step(4); look;
      `CHK(reset_shared_data_out, 1'b1)
      step(1); r_en <= 1'b0; reset_pin_pullup_en_in <= 1'b1; look;
      `CHK(reset_shared_pullup_out, 1'b1)
      rst_chk();
      step(2);
      give_verdict();
   end
endmodule // tb_top
`default_nettype wire
